// ### core/msg_validator_pkg.sv
// Constants, enumerations and carriers for the control message validator.
// Assumes byte-wide frame delivery from a transport layer and an AXI4-Lite host.
package msg_validator_pkg;

  // Frame and header layout.
  localparam logic [7:0] CHANNEL_CTRL    = 8'h00;
  localparam logic [7:0] MESSAGE_MARKER  = 8'h83;
  localparam logic [5:0] MAX_LEN         = 6'h20;
  localparam int         POS_MARKER      = 0;
  localparam int         POS_CODE        = 1;
  localparam int         POS_TAG_HI      = 2;
  localparam int         POS_TAG_LO      = 3;
  localparam int         POS_ROUTE_0     = 4;
  localparam int         POS_ROUTE_1     = 5;
  localparam int         POS_ROUTE_2     = 6;
  localparam int         POS_ROUTE_3     = 7;
  localparam int         POS_LUN         = 8;
  localparam int         POS_CMD_RSVD_A  = 9;
  localparam int         POS_CMD_FLAGS   = 10;
  localparam int         POS_CMD_RSVD_B  = 11;
  localparam int         POS_CHANNEL     = 12;
  localparam int         POS_CMD_RSVD_C  = 14;
  localparam int         POS_CMD_RSVD_D  = 15;
  localparam int         RESUME_BIT      = 5;
  localparam logic [7:0] FLAGS_RSVD_MASK = 8'h0C;

  // Function codes.
  localparam logic [7:0] FC_RESPONSE      = 8'h03;
  localparam logic [7:0] FC_COMMAND       = 8'h10;
  localparam logic [7:0] FC_STATUS        = 8'h11;
  localparam logic [7:0] FC_CONFIRM       = 8'h12;
  localparam logic [7:0] FC_EVENT_ENABLE  = 8'h20;
  localparam logic [7:0] FC_EVENT_REPORT  = 8'h21;
  localparam logic [7:0] FC_ABORT_TASK    = 8'h30;
  localparam logic [7:0] FC_CLEAR_ALLEG   = 8'h34;
  localparam logic [7:0] FC_LU_RESET      = 8'h35;

  // Shortest defined message per kind, in bytes.
  localparam logic [5:0] LEN_TGT_HDR  = 6'h04;
  localparam logic [5:0] LEN_INIT_HDR = 6'h08;
  localparam logic [5:0] LEN_TM       = 6'h09;
  localparam logic [5:0] LEN_COMMAND  = 6'h10;

  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL        = 12'h000;
  localparam logic [11:0] OFF_ROUTE_VALID = 12'h004;
  localparam logic [11:0] OFF_FLOW_STATE  = 12'h008;
  localparam logic [11:0] OFF_TM_CLEAR    = 12'h00C;
  localparam logic [11:0] OFF_LAST        = 12'h010;
  localparam logic [11:0] OFF_ROUTE_BASE  = 12'h020;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0003;
  localparam int          CTRL_TARGET_BIT = 0;
  localparam int          CTRL_ENABLE_BIT = 1;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    KIND_ACCEPT, KIND_ALERT, KIND_RESPONSE, KIND_STATUS, KIND_DROP
  } verdict_kind_t;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_UNKNOWN_MSG, CAUSE_UNKNOWN_ROUTE, CAUSE_TOO_SHORT,
    CAUSE_OVERLAPPED, CAUSE_INVALID_FIELD, CAUSE_TASK_SET_FULL
  } cause_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } msg_beat_t;

  typedef struct packed {
    verdict_kind_t kind;
    cause_t        cause;
    logic [7:0]    function_code;
    logic [15:0]   tag;
    logic [7:0]    initiator;
    logic [7:0]    lun;
    logic [7:0]    channel;
  } verdict_t;

endpackage : msg_validator_pkg

// ### core/storage_message_validator.sv
// Receive-side header parser and validator for protocol control messages.
// Assumes one message per frame delivered byte by byte, and an AXI4-Lite host.
// How it works
// - Only frames on channel 00h whose byte 0 is marker 83h are examined.
// - Byte 1 is taken as the function code selecting the operation.
// - A frame's last beat ends the message; one message per frame.
// - Messages are at most 32 bytes; bytes past 32 are ignored.
// - Pad bytes beyond the defined length are never inspected.
// - Channel first byte is passed through; the second byte is never checked.
// - Initiator messages: tag bytes 2-3, route id bytes 4-7, LUN byte 8.
// - Target messages: marker, code and tag in bytes 0-3.
// - Function codes decode to the twelve defined operations.
// - Marker is checked first, then code checks precede length and field checks.
// - Undefined code raises an unknown-message alert, no other reply.
// - Code meant for the other role raises an unknown-message alert.
// - Non-application frame type raises an unknown-message alert.
// - Unknown return route id raises an unknown-route alert.
// - Second outstanding task-management request other than LU reset gets an overlapped response.
// - Full storage, no prior discard: discard, status task set full.
// - After a discard, commands without resume are silently dropped.
// - Full storage, prior discard, resume set: discard, task set full.
// - Resume set without prior discard: invalid-field response.
// - Room, prior discard, resume set: accept and continue validation.
// - Message shorter than defined raises a too-short alert.
// - Non-zero reserved command field gets an invalid-field response.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module storage_message_validator
  import msg_validator_pkg::*;
#(
  parameter int NUM_ROUTES = 4
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [11:0]   awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [11:0]   araddr,
  input  wire logic [2:0]    arprot,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  input  wire logic          beat_valid,
  input  wire msg_beat_t     beat,
  input  wire logic          frame_app,
  input  wire logic [7:0]    frame_channel,
  input  wire logic          storage_full,
  output logic               verdict_valid,
  output verdict_t           verdict
);

  localparam int IDX_W = (NUM_ROUTES > 1) ? $clog2(NUM_ROUTES) : 1;

  logic [7:0]            msg [MAX_LEN];
  logic [5:0]            byte_cnt;
  logic [5:0]            msg_len;
  logic                  frame_ok;
  logic                  frame_is_app;
  logic                  eval;
  logic [31:0]           ctrl;
  logic [NUM_ROUTES-1:0] route_valid;
  logic [31:0]           route_id [NUM_ROUTES];
  logic [NUM_ROUTES-1:0] discarded;
  logic [NUM_ROUTES-1:0] tm_pending;
  logic [NUM_ROUTES-1:0] tm_clear;
  logic                  aw_held;
  logic                  w_held;
  logic [11:0]           wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_go;
  verdict_t              next_verdict;
  logic                  next_report;
  logic                  set_discard;
  logic                  clr_discard;
  logic                  set_tm;
  logic [IDX_W-1:0]      hit_idx;
  logic                  hit;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Frame intake; no back-pressure, so a frame may follow the previous one at once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_cnt     <= 6'h00;
      msg_len      <= 6'h00;
      frame_ok     <= 1'b0;
      frame_is_app <= 1'b0;
      eval         <= 1'b0;
    end else begin
      eval <= 1'b0;
      if (beat_valid) begin
        if (beat.first) begin
          byte_cnt     <= 6'h01;
          frame_is_app <= frame_app;
          frame_ok     <= (frame_channel == CHANNEL_CTRL) && ctrl[CTRL_ENABLE_BIT];
        end else if (byte_cnt < MAX_LEN) begin
          byte_cnt <= byte_cnt + 6'h01;
        end
        if (beat.last) begin
          eval    <= 1'b1;
          msg_len <= beat.first ? 6'h01 : ((byte_cnt < MAX_LEN) ? byte_cnt + 6'h01 : MAX_LEN);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (beat_valid) begin
      if (beat.first) begin
        msg[0] <= beat.data;
      end else if (byte_cnt < MAX_LEN) begin
        msg[byte_cnt[4:0]] <= beat.data;
      end
    end
  end

  // Return route lookup names the initiator.
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < NUM_ROUTES; i++) begin
      if (!hit && route_valid[i] && route_id[i] == {msg[POS_ROUTE_0], msg[POS_ROUTE_1],
                                                   msg[POS_ROUTE_2], msg[POS_ROUTE_3]}) begin
        hit     = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  // Validation in the documented order; the first failing check decides.
  always_comb begin
    logic [7:0] code;
    logic       known;
    logic       to_target;
    logic       is_tm;
    logic       is_cmd;
    logic       resume;
    logic       fields_bad;
    logic [5:0] min_len;
    min_len     = LEN_TGT_HDR;
    code        = msg[POS_CODE];
    is_cmd      = (code == FC_COMMAND);
    is_tm       = (code >= FC_ABORT_TASK) && (code <= FC_CLEAR_ALLEG);
    to_target   = is_cmd || code == FC_CONFIRM || code == FC_EVENT_ENABLE ||
                  ((code >= FC_ABORT_TASK) && (code <= FC_LU_RESET));
    known       = to_target || code == FC_RESPONSE || code == FC_STATUS ||
                  code == FC_EVENT_REPORT;
    resume      = msg[POS_CMD_FLAGS][RESUME_BIT];
    fields_bad  = (msg[POS_CMD_RSVD_A] != 8'h00) || ((msg[POS_CMD_FLAGS] & FLAGS_RSVD_MASK) != 8'h00)
                  || (msg[POS_CMD_RSVD_B] != 8'h00) || (msg[POS_CMD_RSVD_C] != 8'h00)
                  || (msg[POS_CMD_RSVD_D] != 8'h00);
    if (is_cmd) begin
      min_len = LEN_COMMAND;
    end else if ((code >= FC_ABORT_TASK) && (code <= FC_LU_RESET)) begin
      min_len = LEN_TM;
    end else if (to_target) begin
      min_len = LEN_INIT_HDR;
    end
    next_verdict.kind          = KIND_ACCEPT;
    next_verdict.cause         = CAUSE_NONE;
    next_verdict.function_code = code;
    next_verdict.tag           = {msg[POS_TAG_HI], msg[POS_TAG_LO]};
    next_verdict.initiator     = 8'(hit_idx);
    next_verdict.lun           = msg[POS_LUN];
    next_verdict.channel       = msg[POS_CHANNEL];
    next_report = eval && frame_ok && msg[POS_MARKER] == MESSAGE_MARKER;
    set_discard = 1'b0;
    clr_discard = 1'b0;
    set_tm      = 1'b0;
    if (!known) begin
      next_verdict.kind  = KIND_ALERT;
      next_verdict.cause = CAUSE_UNKNOWN_MSG;
    end else if (to_target != ctrl[CTRL_TARGET_BIT]) begin
      next_verdict.kind  = KIND_ALERT;
      next_verdict.cause = CAUSE_UNKNOWN_MSG;
    end else if (!frame_is_app) begin
      next_verdict.kind  = KIND_ALERT;
      next_verdict.cause = CAUSE_UNKNOWN_MSG;
    end else if (to_target && !hit) begin
      next_verdict.kind  = KIND_ALERT;
      next_verdict.cause = CAUSE_UNKNOWN_ROUTE;
    end else if (is_tm && tm_pending[hit_idx]) begin
      next_verdict.kind  = KIND_RESPONSE;
      next_verdict.cause = CAUSE_OVERLAPPED;
    end else if (is_cmd && storage_full && !discarded[hit_idx]) begin
      next_verdict.kind  = KIND_STATUS;
      next_verdict.cause = CAUSE_TASK_SET_FULL;
      set_discard        = 1'b1;
    end else if (is_cmd && discarded[hit_idx] && !resume) begin
      next_verdict.kind  = KIND_DROP;
    end else if (is_cmd && storage_full && discarded[hit_idx]) begin
      next_verdict.kind  = KIND_STATUS;
      next_verdict.cause = CAUSE_TASK_SET_FULL;
    end else if (is_cmd && !discarded[hit_idx] && resume) begin
      next_verdict.kind  = KIND_RESPONSE;
      next_verdict.cause = CAUSE_INVALID_FIELD;
    end else if (msg_len < min_len) begin
      next_verdict.kind  = KIND_ALERT;
      next_verdict.cause = CAUSE_TOO_SHORT;
    end else if (is_cmd && fields_bad) begin
      next_verdict.kind  = KIND_RESPONSE;
      next_verdict.cause = CAUSE_INVALID_FIELD;
    end else begin
      clr_discard = is_cmd && discarded[hit_idx];
      set_tm      = is_tm;
    end
    if (!next_report) begin
      set_discard = 1'b0;
      clr_discard = 1'b0;
      set_tm      = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verdict_valid <= 1'b0;
      verdict       <= '0;
    end else begin
      verdict_valid <= next_report;
      if (next_report) begin
        verdict <= next_verdict;
      end
    end
  end

  // Flow-control memory per initiator.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      discarded <= '0;
    end else if (set_discard) begin
      discarded[hit_idx] <= 1'b1;
    end else if (clr_discard) begin
      discarded[hit_idx] <= 1'b0;
    end
  end

  // Software retires a task-management request; a new one in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tm_pending <= '0;
    end else begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        if (set_tm && hit_idx == IDX_W'(i)) begin
          tm_pending[i] <= 1'b1;
        end else if (tm_clear[i]) begin
          tm_pending[i] <= 1'b0;
        end
      end
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  assign wr_go = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wr_addr <= 12'h000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    return a == OFF_CTRL || a == OFF_ROUTE_VALID || a == OFF_FLOW_STATE || a == OFF_TM_CLEAR
           || a == OFF_LAST || (a >= OFF_ROUTE_BASE && a < OFF_ROUTE_BASE + 12'(4 * NUM_ROUTES)
           && a[1:0] == 2'h0);
  endfunction : mapped

  always_comb begin
    tm_clear = '0;
    if (wr_go && wr_addr == OFF_TM_CLEAR) begin
      tm_clear = wr_data[NUM_ROUTES-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl        <= CTRL_RESET;
      route_valid <= '0;
    end else if (wr_go) begin
      if (wr_addr == OFF_CTRL) begin
        ctrl <= merge(ctrl, wr_data, wr_strb) & CTRL_RESET;
      end
      if (wr_addr == OFF_ROUTE_VALID) begin
        route_valid <= NUM_ROUTES'(merge(32'(route_valid), wr_data, wr_strb));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        route_id[i] <= 32'h0000_0000;
      end
    end else if (wr_go) begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        if (wr_addr == OFF_ROUTE_BASE + 12'(4 * i)) begin
          route_id[i] <= merge(route_id[i], wr_data, wr_strb);
        end
      end
    end
  end

  // AXI4-Lite read path: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata   <= read_word(araddr);
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFF_CTRL:        r = ctrl;
      OFF_ROUTE_VALID: r = 32'(route_valid);
      OFF_FLOW_STATE:  r = {16'h0000, 8'(tm_pending), 8'(discarded)};
      OFF_LAST:        r = {8'(verdict.kind), 8'(verdict.cause), verdict.tag};
      default: begin
        for (int i = 0; i < NUM_ROUTES; i++) begin
          if (a == OFF_ROUTE_BASE + 12'(4 * i)) begin
            r = route_id[i];
          end
        end
      end
    endcase
    return r;
  endfunction : read_word

endmodule : storage_message_validator
`default_nettype wire

// ### tb/msg_validator_monitor.sv
// Concurrent checks on the validator's message link and verdict port.
// Assumes frames arrive with at least one idle cycle between them.
`timescale 1ns/10ps
`default_nettype none
module msg_validator_monitor
  import msg_validator_pkg::*;
#(
  parameter int NUM_ROUTES = 4
) (
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      beat_valid,
  input wire msg_beat_t beat,
  input wire logic      frame_app,
  input wire logic      verdict_valid,
  input wire verdict_t  verdict
);
  logic [5:0]  idx;
  logic [7:0]  code;
  logic [15:0] tag;
  logic        app;
  logic        known;
  // Byte positions are tracked here so each verdict can be tied to what was sent.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx <= 6'h00;
    end else if (beat_valid) begin
      idx <= beat.first ? 6'h01 : idx + 6'h01;
      if (beat.first) app <= frame_app;
      if (!beat.first && idx == 6'h01) code <= beat.data;
      if (!beat.first && idx == 6'h02) tag[15:8] <= beat.data;
      if (!beat.first && idx == 6'h03) tag[7:0] <= beat.data;
    end
  end
  assign known = (code inside {FC_RESPONSE, FC_COMMAND, FC_STATUS, FC_CONFIRM,
                  FC_EVENT_ENABLE, FC_EVENT_REPORT}) || (code >= FC_ABORT_TASK && code <= FC_LU_RESET);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_verdict_after_last: assert property (
    verdict_valid |-> $past(beat_valid && beat.last, 2)) else $error("no last beat");
  a_code_copied: assert property (
    verdict_valid |-> verdict.function_code == code) else $error("code lost");
  a_tag_copied: assert property (
    verdict_valid |-> verdict.tag == tag) else $error("tag lost");
  a_unknown_code: assert property (
    verdict_valid && !known |-> verdict.kind == KIND_ALERT && verdict.cause == CAUSE_UNKNOWN_MSG)
    else $error("no unknown alert");
  a_frame_type: assert property (
    verdict_valid && !app |-> verdict.kind == KIND_ALERT && verdict.cause == CAUSE_UNKNOWN_MSG)
    else $error("no frame alert");
  a_overlap_code: assert property (
    verdict_valid && verdict.cause == CAUSE_OVERLAPPED |-> verdict.kind == KIND_RESPONSE
    && code >= FC_ABORT_TASK && code < FC_LU_RESET) else $error("bad overlap");
  a_drop_command: assert property (
    verdict_valid && verdict.kind == KIND_DROP |-> code == FC_COMMAND) else $error("bad drop");
  a_full_status: assert property (
    verdict_valid && verdict.kind == KIND_STATUS |-> verdict.cause == CAUSE_TASK_SET_FULL
    && code == FC_COMMAND) else $error("bad status");
  a_verdict_holds: assert property (
    $changed(verdict) |-> verdict_valid) else $error("verdict moved");
  c_drop: cover property (verdict_valid && verdict.kind == KIND_DROP);
  c_full: cover property (verdict_valid && verdict.kind == KIND_STATUS);
  c_overlap: cover property (verdict_valid && verdict.cause == CAUSE_OVERLAPPED);
endmodule : msg_validator_monitor
bind storage_message_validator msg_validator_monitor #(.NUM_ROUTES(NUM_ROUTES)) i_mon (
  .aclk(aclk), .aresetn(aresetn), .beat_valid(beat_valid), .beat(beat),
  .frame_app(frame_app), .verdict_valid(verdict_valid), .verdict(verdict));
`default_nettype wire

// ### tb/msg_link_source.sv
// Model of the remote initiator's controller that sends control messages.
// Assumes the bench calls send for one frame at a time.
`timescale 1ns/10ps
`default_nettype none
module msg_link_source
  import msg_validator_pkg::*;
(
  input  wire logic  aclk,
  output msg_beat_t  beat,
  output logic       beat_valid,
  output logic       frame_app,
  output logic [7:0] frame_channel
);
  typedef logic [7:0] byte_q_t[$];
  initial begin
    beat_valid = 1'b0;
    beat = '0;
    frame_app = 1'b1;
    frame_channel = 8'h00;
  end
  // Builds an initiator message; byte 13 is set to 5Ah, other unused bytes stay zero as padding.
  function automatic byte_q_t mk(input logic [7:0] code, input logic [15:0] tag,
                                 input logic [31:0] route, input int len,
                                 input logic [7:0] flags = 8'h00);
    byte_q_t q;
    for (int i = 0; i < len; i++) q.push_back(8'h00);
    q[0] = MESSAGE_MARKER;
    q[1] = code;
    q[2] = tag[15:8];
    q[3] = tag[7:0];
    for (int i = 0; i < 4 && len > 7; i++) q[4 + i] = route[31 - 8 * i -: 8];
    if (len > 10) q[10] = flags;
    if (len > 13) q[13] = 8'h5a;
    return q;
  endfunction : mk
  // One frame holds the whole message; gap slows the source between beats.
  // Idle data toggles so a stale byte never looks live.
  task automatic send(input byte_q_t b, input logic app, input logic [7:0] ch, input int gap);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge aclk);
      beat_valid <= 1'b1;
      beat <= '{data: b[i], first: i == 0, last: i == b.size() - 1};
      frame_app <= app;
      frame_channel <= ch;
      repeat (i < b.size() - 1 ? gap : 0) begin
        @(posedge aclk);
        beat_valid <= 1'b0;
        beat.data <= ~beat.data;
      end
    end
    @(posedge aclk);
    beat_valid <= 1'b0;
    beat.data <= ~beat.data;
  endtask : send
endmodule : msg_link_source
`default_nettype wire

// ### tb/tb_storage_message_validator.sv
// Self-checking bench for the control message validator.
// Assumes the link source model and the bound monitor are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module tb_storage_message_validator
  import msg_validator_pkg::*;
;
  localparam logic [31:0] ROUTE = 32'h1234_5678;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, beat_valid, frame_app, storage_full, verdict_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  frame_channel;
  msg_beat_t   beat;
  verdict_t    verdict;
  logic [7:0]  q[$];
  logic [7:0]  codes[9] = '{8'h10, 8'h12, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
  logic [7:0]  icodes[3] = '{8'h03, 8'h11, 8'h21};
  int n_fail = 0;
  int checks = 0;
  int gap = 0;
  storage_message_validator #(.NUM_ROUTES(4)) i_dut (.*, .awprot(3'h0), .arprot(3'h0));
  msg_link_source i_src (.aclk(aclk), .beat(beat), .beat_valid(beat_valid),
    .frame_app(frame_app), .frame_channel(frame_channel));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Sends q and waits a bounded time for the verdict pulse.
  task automatic frm(input verdict_kind_t k, input cause_t c, input logic app = 1'b1,
                     input logic [7:0] ch = 8'h00, input logic has_v = 1'b1);
    int n;
    i_src.send(q, app, ch, gap);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!verdict_valid && n < 6);
    check("verdict_valid", verdict_valid, has_v);
    if (has_v) begin
      check("kind", verdict.kind, k);
      if (k != KIND_DROP) check("cause", verdict.cause, c);
      check("tag", verdict.tag, {q[2], q[3]});
      check("code", verdict.function_code, q[1]);
    end
  endtask : frm
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, storage_full} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFF_CTRL);
    check("ctrl", rd, CTRL_RESET);
    axi_rd(OFF_FLOW_STATE);
    check("flow", rd, 32'h0000_0000);
    axi_rd(12'h100);
    check("unmapped", resp, RESP_SLVERR);
    axi_wr(OFF_ROUTE_BASE, ROUTE);
    axi_wr(OFF_ROUTE_VALID, 32'h0000_0001);
    axi_rd(OFF_ROUTE_BASE);
    check("route", rd, ROUTE);
    $display("test registers done");
    q = i_src.mk(8'h55, 16'h0001, ROUTE, 8);
    frm(KIND_ALERT, CAUSE_UNKNOWN_MSG);
    for (int i = 0; i < 3; i++) begin
      q = i_src.mk(icodes[i], 16'h0010 + 16'(i), ROUTE, 8);
      frm(KIND_ALERT, CAUSE_UNKNOWN_MSG);
    end
    q = i_src.mk(FC_CONFIRM, 16'h0020, ROUTE, 8);
    frm(KIND_ALERT, CAUSE_UNKNOWN_MSG, 1'b0);
    q = i_src.mk(FC_CONFIRM, 16'h0021, 32'hdead_beef, 8);
    frm(KIND_ALERT, CAUSE_UNKNOWN_ROUTE);
    q = i_src.mk(FC_CONFIRM, 16'h0022, ROUTE, 8);
    frm(KIND_ACCEPT, CAUSE_NONE, 1'b1, 8'h01, 1'b0);
    q[0] = 8'h82;
    frm(KIND_ACCEPT, CAUSE_NONE, 1'b1, 8'h00, 1'b0);
    $display("test code checks done");
    gap = 2;
    for (int i = 0; i < 9; i++) begin
      q = i_src.mk(codes[i], 16'h0100 + 16'(i), ROUTE, i == 0 ? 16 : (i > 2 ? 9 : 8));
      frm(KIND_ACCEPT, CAUSE_NONE);
      axi_wr(OFF_TM_CLEAR, 32'h0000_0001);
    end
    gap = 0;
    q = i_src.mk(FC_ABORT_TASK, 16'h0200, ROUTE, 9);
    frm(KIND_ACCEPT, CAUSE_NONE);
    axi_rd(OFF_FLOW_STATE);
    check("pending", rd, 32'h0000_0100);
    q = i_src.mk(8'h32, 16'h0201, ROUTE, 9);
    frm(KIND_RESPONSE, CAUSE_OVERLAPPED);
    q = i_src.mk(FC_LU_RESET, 16'h0202, ROUTE, 9);
    frm(KIND_ACCEPT, CAUSE_NONE);
    axi_wr(OFF_TM_CLEAR, 32'h0000_0001);
    $display("test task management done");
    storage_full <= 1'b1;
    q = i_src.mk(FC_COMMAND, 16'h0300, ROUTE, 16);
    frm(KIND_STATUS, CAUSE_TASK_SET_FULL);
    axi_rd(OFF_FLOW_STATE);
    check("discard", rd, 32'h0000_0001);
    storage_full <= 1'b0;
    frm(KIND_DROP, CAUSE_NONE);
    storage_full <= 1'b1;
    q = i_src.mk(FC_COMMAND, 16'h0301, ROUTE, 16, 8'h20);
    frm(KIND_STATUS, CAUSE_TASK_SET_FULL);
    storage_full <= 1'b0;
    frm(KIND_ACCEPT, CAUSE_NONE);
    axi_rd(OFF_FLOW_STATE);
    check("discard", rd, 32'h0000_0000);
    frm(KIND_RESPONSE, CAUSE_INVALID_FIELD);
    q = i_src.mk(FC_COMMAND, 16'h0302, ROUTE, 16, 8'h04);
    frm(KIND_RESPONSE, CAUSE_INVALID_FIELD);
    q = i_src.mk(FC_COMMAND, 16'h0303, ROUTE, 10);
    frm(KIND_ALERT, CAUSE_TOO_SHORT);
    q = i_src.mk(FC_COMMAND, 16'h0304, ROUTE, 32);
    q[31] = 8'hff;
    q[8] = 8'h07;
    q[12] = 8'h3c;
    frm(KIND_ACCEPT, CAUSE_NONE);
    check("lun", verdict.lun, 8'h07);
    check("channel", verdict.channel, 8'h3c);
    axi_rd(OFF_LAST);
    check("last", rd, {5'h00, KIND_ACCEPT, 5'h00, CAUSE_NONE, 16'h0304});
    $display("test command flow done");
    axi_wr(OFF_CTRL, 32'h0000_0002);
    q = i_src.mk(FC_RESPONSE, 16'h0400, ROUTE, 4);
    frm(KIND_ACCEPT, CAUSE_NONE);
    q = i_src.mk(FC_COMMAND, 16'h0401, ROUTE, 16);
    frm(KIND_ALERT, CAUSE_UNKNOWN_MSG);
    axi_wr(OFF_CTRL, 32'h0000_0001);
    frm(KIND_ACCEPT, CAUSE_NONE, 1'b1, 8'h00, 1'b0);
    $display("test initiator role done");
    complete_run;
  end
endmodule : tb_storage_message_validator
`default_nettype wire
